// ### hdl/swic_top.sv
`timescale 1ns/10ps
module swic_top import swic_pkg::*; #(
  parameter int unsigned HALF_CYC = SWIC_HALF_CYC,
  parameter int unsigned AW       = 20
) (
  // clock and reset
  input  wire logic          mclk,
  input  wire logic          rst,
  // apb slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [AW-1:0] paddr,
  input  wire logic [31:0]   pwdata,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  // pins: clock, data out, data in
  input  wire logic          clk_pin_i,
  input  wire logic          so_pin_i,
  input  wire logic          si_pin_i,
  output swic_pin_t          clk_pin,
  output swic_pin_t          so_pin,
  output swic_pin_t          si_pin,
  // port logic drive for stopped channel, [0]=clk [1]=so [2]=si
  input  swic_pin_t [2:0]    port_drive,
  // events
  output logic               channel_irq_flag,
  output logic               channel_interrupt
);

  // ********************************
  // registers and state
  // ********************************
  logic [7:0] mode_q, timing_q, shift_q, saddr_q;
  logic [3:0] cnt_q;
  logic       busy_q, wait_q, wpend_q, so_q, lvl_q;
  logic       flag_q, irq_q;
  logic [7:0] div_q;
  logic       scl1_q, scl2_q, scl3_q, sda1_q, sda2_q, sda3_q, sdi1_q, sdi2_q;

  // ********************************
  // apb decode
  // ********************************
  wire         wr_acc  = psel & penable & pwrite;
  wire [AW-1:0] a_mode  = AW'({SWIC_MODE_IDX, 2'b00});
  wire [AW-1:0] a_time  = AW'({SWIC_TIMING_IDX, 2'b00});
  wire [AW-1:0] a_shift = AW'({SWIC_SHIFT_IDX, 2'b00});
  wire [AW-1:0] a_saddr = AW'({SWIC_SADDR_IDX, 2'b00});
  wire [AW-1:0] a_stat  = AW'({SWIC_STATUS_IDX, 2'b00});
  wire [AW-1:0] a_bitop = AW'({SWIC_BITOP_IDX, 2'b00});
  wire         hit_mode  = paddr == a_mode;
  wire         hit_time  = paddr == a_time;
  wire         hit_shift = paddr == a_shift;
  wire         hit_saddr = paddr == a_saddr;
  wire         hit_stat  = paddr == a_stat;
  wire         hit_bitop = paddr == a_bitop;
  wire         hit_any   = hit_mode | hit_time | hit_shift | hit_saddr | hit_stat | hit_bitop;

  // bit writes: pwdata[2:0] bit, [3] target timing, [4] value
  wire [7:0]   bit_sel   = 8'h01 << pwdata[2:0];
  wire         bop       = wr_acc & hit_bitop;
  wire [7:0]   mode_bop  = pwdata[4] ? (mode_q | bit_sel) : (mode_q & ~bit_sel);
  wire [7:0]   time_bop  = pwdata[4] ? (timing_q | bit_sel) : (timing_q & ~bit_sel);
  wire         mode_we   = (wr_acc & hit_mode) | (bop & ~pwdata[3]);
  wire         time_we   = (wr_acc & hit_time) | (bop & pwdata[3]);
  wire [7:0]   mode_wv   = hit_bitop ? mode_bop : pwdata[7:0];
  wire [7:0]   time_wv   = hit_bitop ? time_bop : pwdata[7:0];

  // ********************************
  // mode decode
  // ********************************
  wire        en      = mode_q[SWIC_EN_BIT];
  wire        i2c     = mode_q[4:3] == SWIC_I2C_MODE;
  wire        master  = mode_q[1];
  wire [1:0]  field   = timing_q[1:0];
  wire        interrupt_source_select     = timing_q[SWIC_SIC_BIT];
  wire        clock_level_control     = timing_q[SWIC_CLC_BIT];
  wire        wait_on = i2c & field[1];
  wire [3:0]  irq_n   = (i2c && field == SWIC_FIELD_9W) ? SWIC_CNT_9 : SWIC_CNT_8;
  wire [3:0]  last_n  = wait_on ? SWIC_CNT_9 : SWIC_CNT_8;
  wire [3:0]  wait_n  = (field == SWIC_FIELD_8W) ? SWIC_CNT_8 : SWIC_CNT_9;
  wire [7:0]  amask   = timing_q[SWIC_ADDRESS_MASK_SELECT_BIT] ? 8'hfe : 8'hff;
  wire        address_compare_result     = en & (((shift_q ^ saddr_q) & amask) == 8'h00);
  wire        clock_pin_level     = en & scl2_q;

  // ********************************
  // serial clock edges
  // ********************************
  // master toggles only while a transfer or pending wait needs the line
  wire        run     = en & master & (busy_q | wpend_q) & ~wait_q;
  wire        tick    = div_q == 8'(HALF_CYC - 1);
  wire        m_rise  = run & tick & ~lvl_q;
  wire        m_fall  = run & tick & lvl_q;
  wire        s_rise  = en & ~master & scl2_q & ~scl3_q;
  wire        s_fall  = en & ~master & ~scl2_q & scl3_q;
  wire        rise    = m_rise | s_rise;
  wire        fall    = m_fall | s_fall;
  wire [3:0]  cnt_nx  = cnt_q + 4'h1;
  wire        brise   = rise & busy_q;
  wire        din     = i2c ? sda2_q : sdi2_q;
  wire        done    = brise & (cnt_nx == last_n);
  wire        irq_hit = brise & (cnt_nx == irq_n);
  wire        stop_ev = en & i2c & scl2_q & sda2_q & ~sda3_q;
  wire        flag_set = irq_hit | (stop_ev & interrupt_source_select);
  wire        flag_clr = wr_acc & hit_stat & pwdata[0];
  wire        start   = wr_acc & hit_shift & en & ~busy_q & ~wait_q;
  wire        release_w = timing_q[SWIC_WAIT_RELEASE_BIT];

  // ********************************
  // pin synchronisers, third stage only for edge finding
  // ********************************
  always_ff @(posedge mclk) begin
    scl1_q <= clk_pin_i;
    scl2_q <= scl1_q;
    scl3_q <= scl2_q;
    sda1_q <= so_pin_i;
    sda2_q <= sda1_q;
    sda3_q <= sda2_q;
    sdi1_q <= si_pin_i;
    sdi2_q <= sdi1_q;
  end

  // ********************************
  // control registers
  // ********************************
  // wait release self clears once the hold is dropped, or at once if none
  always_ff @(posedge mclk) begin
    if (rst) begin
      mode_q   <= SWIC_MODE_RST;
      timing_q <= SWIC_TIME_RST;
      saddr_q  <= 8'h00;
    end else begin
      if (mode_we) mode_q <= mode_wv & SWIC_MODE_WMSK;
      if (time_we) timing_q <= time_wv & SWIC_TIME_WMSK;
      else if (release_w) timing_q[SWIC_WAIT_RELEASE_BIT] <= 1'b0;
      if (wr_acc && hit_saddr) saddr_q <= pwdata[7:0];
    end
  end

  // ********************************
  // master clock divider and level
  // ********************************
  always_ff @(posedge mclk) begin
    if (rst || !run) div_q <= 8'h00;
    else div_q <= tick ? 8'h00 : div_q + 8'h01;
  end

  always_ff @(posedge mclk) begin
    if (rst || !en) lvl_q <= 1'b1;
    else if (run && tick) lvl_q <= ~lvl_q;
  end

  // ********************************
  // transfer engine
  // ********************************
  // shifting only with the channel enabled, else shift_q is plain storage
  always_ff @(posedge mclk) begin
    if (rst) begin
      shift_q <= 8'h00;
    end else if (wr_acc && hit_shift && !busy_q) begin
      shift_q <= pwdata[7:0];
    end else if (brise && cnt_q < SWIC_CNT_8) begin
      shift_q <= {shift_q[6:0], din};
    end
  end

  always_ff @(posedge mclk) begin
    if (rst || !en) begin
      busy_q  <= 1'b0;
      cnt_q   <= 4'h0;
      so_q    <= 1'b1;
      wpend_q <= 1'b0;
      wait_q  <= 1'b0;
    end else begin
      if (start) begin
        busy_q <= 1'b1;
        cnt_q  <= 4'h0;
        so_q   <= pwdata[7];
      end else if (brise) begin
        cnt_q <= cnt_nx;
        if (done) busy_q <= 1'b0;
      end
      // next bit out on the falling edge, line freed for the ack slot
      if (fall && busy_q && cnt_q != 4'h0) so_q <= (cnt_q < SWIC_CNT_8) ? shift_q[7] : 1'b1;
      if (brise && wait_on && cnt_nx == wait_n) wpend_q <= 1'b1;
      else if (fall && wpend_q) wpend_q <= 1'b0;
      if (fall && wpend_q) wait_q <= 1'b1;
      else if (release_w && wait_q) wait_q <= 1'b0;
    end
  end

  // ********************************
  // interrupt flag, set wins over clear
  // ********************************
  always_ff @(posedge mclk) begin
    if (rst) begin
      flag_q <= 1'b0;
      irq_q  <= 1'b0;
    end else begin
      flag_q <= flag_set | (flag_q & ~flag_clr);
      irq_q  <= flag_set;
    end
  end

  assign channel_irq_flag  = flag_q;
  assign channel_interrupt = irq_q;

  // ********************************
  // pin drive
  // ********************************
  // i2c lines are open drain: only ever pulled low
  wire clk_low_i2c = wait_q | (~busy_q & ~wpend_q & ~clock_level_control) | (master & busy_q & ~lvl_q);
  wire clk_hold_3w = ~i2c & master;
  assign clk_pin = !en ? port_drive[0] :
                   i2c ? '{o: 1'b0, oe_n: ~clk_low_i2c} :
                   '{o: lvl_q, oe_n: ~clk_hold_3w};
  assign so_pin  = !en ? port_drive[1] :
                   i2c ? '{o: 1'b0, oe_n: so_q} :
                   '{o: so_q, oe_n: 1'b0};
  assign si_pin  = !en ? port_drive[2] : '{o: 1'b0, oe_n: 1'b1};

  // ********************************
  // apb read path, zero wait state
  // ********************************
  wire [7:0] mode_rd = {mode_q[7], address_compare_result, mode_q[5:0]};
  wire [7:0] time_rd = {1'b0, clock_pin_level, timing_q[5:0]};
  wire [7:0] stat_rd = {5'h00, wait_q, busy_q, flag_q};
  wire [7:0] rd_mux  = hit_mode  ? mode_rd :
                       hit_time  ? time_rd :
                       hit_shift ? shift_q :
                       hit_saddr ? saddr_q :
                       hit_stat  ? stat_rd : 8'h00;
  assign prdata  = {24'h000000, rd_mux};
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit_any;

  // ********************************
  // checks
  // ********************************
  irq_at_eighth_a: assert property (@(posedge mclk) disable iff (rst)
    (brise && cnt_nx == SWIC_CNT_8 && !(i2c && field == SWIC_FIELD_9W)) |=> irq_q && flag_q)
    else $error("no interrupt at eighth clock");
  irq_at_ninth_a: assert property (@(posedge mclk) disable iff (rst)
    (brise && i2c && field == SWIC_FIELD_9W && cnt_nx == SWIC_CNT_9) |=> irq_q)
    else $error("no interrupt at ninth clock");
  hold_after_wait_a: assert property (@(posedge mclk) disable iff (rst)
    (fall && wpend_q && en && !mode_we) |=> wait_q && !clk_pin.oe_n && !clk_pin.o)
    else $error("clock not held low in wait");
  release_clears_a: assert property (@(posedge mclk) disable iff (rst)
    (release_w && !time_we && en) |=> !release_w && !wait_q)
    else $error("wait release did not clear");
  idle_low_a: assert property (@(posedge mclk) disable iff (rst)
    (en && i2c && !clock_level_control && !busy_q && !wpend_q) |-> !clk_pin.oe_n && !clk_pin.o)
    else $error("idle clock not driven low");
  idle_free_a: assert property (@(posedge mclk) disable iff (rst)
    (en && i2c && clock_level_control && !busy_q && !wait_q && !wpend_q) |-> clk_pin.oe_n)
    else $error("idle clock not released");
  level_off_a: assert property (@(posedge mclk) disable iff (rst)
    (!en && psel && !pwrite && hit_time) |-> prdata[SWIC_CLD_BIT] == 1'b0)
    else $error("pin level shown while disabled");
  bit7_zero_a: assert property (@(posedge mclk) disable iff (rst)
    time_we |=> timing_q[7] == 1'b0)
    else $error("timing bit 7 written");
  stop_flag_a: assert property (@(posedge mclk) disable iff (rst)
    (stop_ev && interrupt_source_select) |=> flag_q)
    else $error("stop condition did not set flag");
  stopped_idle_a: assert property (@(posedge mclk) disable iff (rst)
    !en |=> !busy_q && clk_pin == port_drive[0] || en)
    else $error("stopped channel still active");
  mask_cmp_a: assert property (@(posedge mclk) disable iff (rst)
    (en && timing_q[SWIC_ADDRESS_MASK_SELECT_BIT] && shift_q[7:1] == saddr_q[7:1]) |-> address_compare_result)
    else $error("masked address compare wrong");

  cov_eight_wait_c: cover property (@(posedge mclk) disable iff (rst) $rose(wait_q) && field == SWIC_FIELD_8W);
  cov_nine_wait_c:  cover property (@(posedge mclk) disable iff (rst) $rose(wait_q) && field == SWIC_FIELD_9W);
  cov_release_c:    cover property (@(posedge mclk) disable iff (rst) $fell(wait_q));
  cov_stop_c:       cover property (@(posedge mclk) disable iff (rst) stop_ev && interrupt_source_select);

endmodule : swic_top

// ### inc/swic_pkg.sv
package swic_pkg;

  // ********************************
  // register indices, byte address is four times the index
  // ********************************
  localparam logic [15:0] SWIC_MODE_IDX   = 16'hff60;
  localparam logic [15:0] SWIC_TIMING_IDX = 16'hff63;
  localparam logic [15:0] SWIC_SHIFT_IDX  = 16'hff68;
  localparam logic [15:0] SWIC_SADDR_IDX  = 16'hff69;
  localparam logic [15:0] SWIC_STATUS_IDX = 16'hff6a;
  localparam logic [15:0] SWIC_BITOP_IDX  = 16'hff6b;

  // ********************************
  // field positions and reset values
  // ********************************
  localparam int unsigned SWIC_EN_BIT    = 7;
  localparam int unsigned SWIC_COI_BIT   = 6;
  localparam int unsigned SWIC_CLD_BIT   = 6;
  localparam int unsigned SWIC_SIC_BIT   = 5;
  localparam int unsigned SWIC_ADDRESS_MASK_SELECT_BIT  = 4;
  localparam int unsigned SWIC_CLC_BIT   = 3;
  localparam int unsigned SWIC_WAIT_RELEASE_BIT  = 2;
  localparam logic [7:0]  SWIC_MODE_RST  = 8'h00;
  localparam logic [7:0]  SWIC_TIME_RST  = 8'h00;
  localparam logic [7:0]  SWIC_TIME_WMSK = 8'h3f;
  localparam logic [7:0]  SWIC_MODE_WMSK = 8'hbf;
  localparam logic [1:0]  SWIC_FIELD_8W  = 2'h2;
  localparam logic [1:0]  SWIC_FIELD_9W  = 2'h3;
  localparam logic [1:0]  SWIC_I2C_MODE  = 2'h3;
  localparam logic [3:0]  SWIC_CNT_8     = 4'h8;
  localparam logic [3:0]  SWIC_CNT_9     = 4'h9;

  // ********************************
  // timing: clock 10 MHz, master serial half period
  // ********************************
  localparam int unsigned SWIC_MCLK_NS   = 100;
  localparam int unsigned SWIC_HALF_NS   = 400;
  localparam int unsigned SWIC_HALF_CYC  = (SWIC_HALF_NS + SWIC_MCLK_NS - 1) / SWIC_MCLK_NS;

  // one pin: output level and active-low output enable
  typedef struct packed {
    logic o;
    logic oe_n;
  } swic_pin_t;

endpackage : swic_pkg

// ### verification/swic_peer.sv
`timescale 1ns/10ps
module swic_peer (
  // pin levels seen on the wires
  input  wire logic clk_w,
  input  wire logic sda_w,
  // lines driven by this peer
  output logic      scl,
  output logic      sda,
  output logic      si
);
  logic [7:0] rx;
  logic [7:0] n_rise;

  // the clock idles high and only moves inside frames
  initial begin
    scl = 1'b1;
    sda = 1'b1;
    si = 1'b0;
    rx = 8'h00;
    n_rise = 8'h00;
  end

  // ****************
  // one frame of n clocks, msb first, 800 ns period
  // ****************
  task automatic frame(input int n, input logic [8:0] tx, input bit i2c);
    n_rise = 8'h00;
    for (int i = n - 1; i >= 0; i--) begin
      scl = 1'b0;
      if (i2c) sda = tx[i];
      else si = tx[i];
      #400;
      scl = 1'b1;
      // a held clock stretches the low phase, bounded
      for (int k = 0; k < 400 && clk_w !== 1'b1; k++) #100;
      rx = {rx[6:0], sda_w};
      n_rise = n_rise + 8'h01;
      #400;
    end
    sda = 1'b1; // open drain, pulled up once let go
    si = ~si; // push-pull line no longer valid: show the opposite level
  endtask : frame

  // start then stop while the clock stays high
  task automatic stop_cond();
    n_rise = 8'h00;
    sda = 1'b0;
    #400;
    sda = 1'b1;
    #400;
  endtask : stop_cond
endmodule : swic_peer

// ### verification/swic_top_tb.sv
`timescale 1ns/10ps
module swic_top_tb import swic_pkg::*;;
  // ****************
  // signals
  // ****************
  logic            mclk = 1'b0;
  logic            rst = 1'b1;
  logic            psel = 1'b0;
  logic            penable = 1'b0;
  logic            pwrite = 1'b0;
  logic [19:0]     paddr = 20'h00000;
  logic [31:0]     pwdata = 32'h00000000;
  logic [31:0]     prdata;
  logic            pready;
  logic            pslverr;
  logic            flag;
  logic            irq;
  swic_pin_t       clk_pin;
  swic_pin_t       so_pin;
  swic_pin_t       si_pin;
  swic_pin_t [2:0] port_drive = '0;
  logic            scl;
  logic            sda;
  logic            si_l;
  logic            clk_w;
  logic            sda_w;
  logic [7:0]      exp_q[$];
  logic [31:0]     seed = 32'h0000d524;
  int              err_total = 0;
  int              n_tests = 0;
  int              cyc = 0;
  localparam logic [19:0] A_MODE  = 20'({SWIC_MODE_IDX, 2'b00});
  localparam logic [19:0] A_TIME  = 20'({SWIC_TIMING_IDX, 2'b00});
  localparam logic [19:0] A_SHIFT = 20'({SWIC_SHIFT_IDX, 2'b00});
  localparam logic [19:0] A_STAT  = 20'({SWIC_STATUS_IDX, 2'b00});
  localparam logic [19:0] A_BITOP = 20'({SWIC_BITOP_IDX, 2'b00});

  always #50 mclk = ~mclk;
  // wired-and of both parties; an undriven device pin counts as high
  assign clk_w = (clk_pin.oe_n ? 1'b1 : clk_pin.o) & scl;
  assign sda_w = (so_pin.oe_n ? 1'b1 : so_pin.o) & sda;

  swic_top #(.AW(20)) dut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .clk_pin_i(clk_w), .so_pin_i(sda_w), .si_pin_i(si_l), .clk_pin(clk_pin), .so_pin(so_pin),
    .si_pin(si_pin), .port_drive(port_drive), .channel_irq_flag(flag), .channel_interrupt(irq));
  swic_peer peer (.clk_w(clk_w), .sda_w(sda_w), .scl(scl), .sda(sda), .si(si_l));

  // ****************
  // helpers
  // ****************
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic stop_test();
    if (err_total == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : stop_test

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // one apb transfer; the #1 lets the edge's register updates land
  task automatic apb(input logic wr, input logic [19:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask : apb

  task automatic wr(input logic [19:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, {24'h000000, d}, r, e);
  endtask : wr

  task automatic rd_chk(input string name, input logic [19:0] a, input logic [7:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h00000000, r, e);
    chk(name, exp, r[7:0]);
  endtask : rd_chk

  task automatic reset_dut();
    @(posedge mclk);
    rst <= 1'b1;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
  endtask : reset_dut

  // i2c slave receive, wait after the nth clock, then release it
  task automatic i2c_wait(input logic [1:0] field, input logic [7:0] n);
    reset_dut();
    wr(A_TIME, {6'h02, field});
    wr(A_MODE, 8'h98);
    wr(A_SHIFT, 8'hff);
    exp_q.push_back(n);
    peer.frame(int'(n), 9'h1ff, 1'b1);
    fork
      peer.frame(1, 9'h1ff, 1'b1);
      begin
        repeat (8) @(posedge mclk);
        chk("clock_held", 8'h00, {6'h00, clk_pin});
        wr(A_TIME, {6'h03, field});
        repeat (4) @(posedge mclk);
        rd_chk("wait_released", A_TIME, {6'h12, field});
      end
    join
  endtask : i2c_wait

  // ****************
  // watchers: interrupt events and timeout
  // ****************
  always @(posedge mclk) begin
    if (!rst && irq === 1'b1)
      chk("irq_rise_count", exp_q.size() > 0 ? exp_q.pop_front() : 8'hee, peer.n_rise);
  end

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_total++;
      stop_test();
    end
  end

  // ****************
  // main sequence
  // ****************
  initial begin
    logic [31:0] r;
    logic        e;
    reset_dut();
    rd_chk("mode_reset", A_MODE, 8'h00);
    rd_chk("timing_reset", A_TIME, 8'h00);
    wr(A_TIME, 8'hbb);
    rd_chk("timing_byte", A_TIME, 8'h3b);
    wr(A_BITOP, 8'h0d);
    rd_chk("timing_bit", A_TIME, 8'h1b);
    wr(A_BITOP, 8'h17);
    rd_chk("mode_bit", A_MODE, 8'hc0);
    wr(A_MODE, 8'h00);
    apb(1'b0, A_MODE + 20'h00004, 32'h00000000, r, e);
    chk("unmapped_err", 8'h01, {7'h00, e});
    // stopped channel: pins follow port logic, shift register is storage
    r = rnd();
    @(posedge mclk);
    port_drive <= r[13:8];
    wr(A_SHIFT, r[7:0]);
    chk("port_pins", {2'h0, r[13:8]}, {2'h0, si_pin, so_pin, clk_pin});
    rd_chk("shift_plain", A_SHIFT, r[7:0]);
    // three-wire slave transfer, interrupt at the 8th rise
    reset_dut();
    wr(A_MODE, 8'h80);
    repeat (4) @(posedge mclk);
    rd_chk("clock_level_high", A_TIME, 8'h40);
    r = rnd();
    wr(A_SHIFT, r[7:0]);
    exp_q.push_back(8'h08);
    peer.frame(8, {1'b0, r[15:8]}, 1'b0);
    repeat (6) @(posedge mclk);
    chk("peer_rx", r[7:0], peer.rx);
    chk("clock_released", 8'h01, {7'h00, clk_pin.oe_n});
    rd_chk("shift_rx", A_SHIFT, r[15:8]);
    wr(A_MODE, 8'h00);
    rd_chk("clock_level_off", A_TIME, 8'h00);
    i2c_wait(SWIC_FIELD_8W, 8'h08);
    i2c_wait(SWIC_FIELD_9W, 8'h09);
    // idle clock level and stop interrupt source
    reset_dut();
    wr(A_MODE, 8'h98);
    repeat (2) @(posedge mclk);
    chk("idle_clock_low", 8'h00, {6'h00, clk_pin});
    wr(A_TIME, 8'h28);
    chk("idle_clock_free", 8'h01, {7'h00, clk_pin.oe_n});
    exp_q.push_back(8'h00);
    peer.stop_cond();
    repeat (6) @(posedge mclk);
    chk("stop_flag", 8'h01, {7'h00, flag});
    wr(A_STAT, 8'h01);
    wr(A_TIME, 8'h08);
    peer.stop_cond();
    repeat (6) @(posedge mclk);
    chk("no_stop_flag", 8'h00, {7'h00, flag});
    chk("pending_irq", 8'h00, 8'(exp_q.size()));
    stop_test();
  end
endmodule : swic_top_tb
